// [design/afe_irq_flags.v]
`timescale 1ns/100ps
`include "afe_irq_map.vh"
// Contract
// - set almost-full flag bit 7 when next sample passes the threshold
// - almost-full clears on status 1 read, or data read if option set
// - sample-ready bit 6 set on new sample in optical modes when enabled
// - sample-ready clears on status 1 read, or data read if option set
// - ambient overflow bit 5 set on saturation, cleared on status 1 read
// - proximity bit 4 set on threshold crossing in proximity mode
// - masked proximity interrupt skips proximity mode, optical sampling starts
// - headroom fault bit 3 set at sample end if low headroom and enabled
// - power-up bit 0 set on digital undervoltage or soft reset
// - supply-range bit 7 of status 2 set while analog supply out of range
// - out-of-range condition qualified for 10ms before setting flag
// - enable bits 7..3 gate flags; bit 4 also enables proximity mode
// - proximity threshold is code times 2048 against emitter conversion count
module afe_irq_flags #(
    parameter QUAL_CYCLES = `SUPPLY_QUAL_CYCLES
) (
    input wire mclk,
    input wire rst,
    input wire reg_rd,
    input wire reg_wr,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire clear_on_data_read,
    input wire optical_mode,
    input wire almost_full_next,
    input wire sample_written,
    input wire ambient_cancel_sat,
    input wire sample_end,
    input wire first_emitter_low_headroom,
    input wire [18:0] first_emitter_count,
    input wire prox_sample_valid,
    input wire digital_supply_low,
    input wire soft_reset,
    input wire analog_supply_oor,
    output wire proximity_mode,
    output wire irq_n
);
    reg [7:0] flags1_q;
    reg flag2_q;
    reg [7:0] en1_q;
    reg en2_q;
    reg [7:0] thresh_q;
    localparam ST_NORMAL = 2'b01;
    localparam ST_PROX = 2'b10;
    reg [1:0] prox_state_q;
    reg [1:0] prox_state_d;
    reg [2:0] dig_sync_q;
    reg [2:0] ana_sync_q;
    reg dig_low_q;
    reg ana_oor_q;
    reg [31:0] qual_cnt_q;
    reg [7:0] set1;
    reg [7:0] clr1;
    wire rd1;
    wire rd2;
    wire rd_data;
    wire [18:0] prox_thresh;
    wire prox_cross;
    wire qual_done;
    wire prox_active;
    wire dig_rise;

    // read strobe aimed at one address
    function addr_hit;
        input strobe;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = strobe && addr == target;
        end
    endfunction

    // sticky bit: a new event outranks the clear
    function sticky_next;
        input held;
        input set_evt;
        input clr_evt;
        begin
            sticky_next = set_evt || (held && !clr_evt);
        end
    endfunction

    assign rd1 = addr_hit(reg_rd, reg_addr, `ADDR_FLAGS_PRIMARY);
    assign rd2 = addr_hit(reg_rd, reg_addr, `ADDR_FLAGS_SECONDARY);
    assign rd_data = addr_hit(reg_rd, reg_addr, `ADDR_FIFO_DATA);
    assign prox_thresh = {thresh_q, 11'h000};
    assign prox_cross = prox_sample_valid && first_emitter_count > prox_thresh;
    assign prox_active = prox_state_q[1];
    assign proximity_mode = prox_state_q[1];
    assign dig_rise = dig_sync_q[1] && dig_sync_q[2] && !dig_low_q;
    assign qual_done = ana_oor_q && qual_cnt_q >= QUAL_CYCLES - 1;

    always @* begin
        set1 = 8'h00;
        set1[`BIT_ALMOST_FULL] = almost_full_next && en1_q[`BIT_ALMOST_FULL];
        set1[`BIT_SAMPLE_READY] = optical_mode && !prox_active && sample_written
            && en1_q[`BIT_SAMPLE_READY];
        set1[`BIT_AMBIENT_OVF] = ambient_cancel_sat && en1_q[`BIT_AMBIENT_OVF];
        set1[`BIT_PROXIMITY] = prox_active && prox_cross && en1_q[`BIT_PROXIMITY];
        set1[`BIT_HEADROOM] = sample_end && first_emitter_low_headroom
            && en1_q[`BIT_HEADROOM];
        set1[`BIT_POWER_UP] = dig_rise || soft_reset;
        clr1 = 8'h00;
        if (rd1) begin
            clr1 = 8'hF9;
        end
        if (rd_data && clear_on_data_read) begin
            clr1[`BIT_ALMOST_FULL] = 1'b1;
            clr1[`BIT_SAMPLE_READY] = 1'b1;
        end
    end

    // proximity mode sequencer
    always @* begin
        prox_state_d = prox_state_q;
        case (prox_state_q)
            ST_NORMAL: begin
                if (en1_q[`BIT_PROXIMITY] && prox_sample_valid && !prox_cross) begin
                    prox_state_d = ST_PROX;
                end
            end
            ST_PROX: begin
                if (!en1_q[`BIT_PROXIMITY]) begin
                    prox_state_d = ST_NORMAL;
                end else if (prox_cross) begin
                    prox_state_d = ST_NORMAL;
                end
            end
            default: begin
                prox_state_d = ST_NORMAL;
            end
        endcase
    end

    // three-stage supply pin synchronisers
    always @(posedge mclk) begin
        if (rst) begin
            dig_sync_q <= 3'h0;
            ana_sync_q <= 3'h0;
            dig_low_q <= 1'b0;
            ana_oor_q <= 1'b0;
        end else begin
            dig_sync_q <= {dig_sync_q[1:0], digital_supply_low};
            ana_sync_q <= {ana_sync_q[1:0], analog_supply_oor};
            if (dig_sync_q[1] == dig_sync_q[2]) begin
                dig_low_q <= dig_sync_q[2];
            end
            if (ana_sync_q[1] == ana_sync_q[2]) begin
                ana_oor_q <= ana_sync_q[2];
            end
        end
    end

    // supply qualification timer
    always @(posedge mclk) begin
        if (rst) begin
            qual_cnt_q <= 32'h00000000;
        end else if (!ana_oor_q) begin
            qual_cnt_q <= 32'h00000000;
        end else if (!qual_done) begin
            qual_cnt_q <= qual_cnt_q + 32'h00000001;
        end
    end

    // enables, threshold, mode state
    always @(posedge mclk) begin
        if (rst) begin
            en1_q <= `ENABLE_RESET;
            en2_q <= 1'b0;
            thresh_q <= 8'h00;
            prox_state_q <= ST_NORMAL;
        end else begin
            prox_state_q <= prox_state_d;
            if (reg_wr) begin
                case (reg_addr)
                    `ADDR_ENABLE_PRIMARY: en1_q <= {reg_wdata[7:3], 3'h0};
                    `ADDR_ENABLE_SECONDARY: en2_q <= reg_wdata[7];
                    `ADDR_PROX_THRESH: thresh_q <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    // sticky flags
    always @(posedge mclk) begin
        if (rst) begin
            flags1_q <= `FLAGS_RESET;
            flag2_q <= 1'b0;
        end else begin
            flags1_q[7] <= sticky_next(flags1_q[7], set1[7], clr1[7]);
            flags1_q[6] <= sticky_next(flags1_q[6], set1[6], clr1[6]);
            flags1_q[5] <= sticky_next(flags1_q[5], set1[5], clr1[5]);
            flags1_q[4] <= sticky_next(flags1_q[4], set1[4], clr1[4]);
            flags1_q[3] <= sticky_next(flags1_q[3], set1[3], clr1[3]);
            flags1_q[2:1] <= 2'h0;
            flags1_q[0] <= sticky_next(flags1_q[0], set1[0], clr1[0]);
            flag2_q <= sticky_next(flag2_q, qual_done && en2_q, rd2);
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_FLAGS_PRIMARY: reg_rdata <= flags1_q & 8'hF9;
                `ADDR_FLAGS_SECONDARY: reg_rdata <= {flag2_q, 7'h00};
                `ADDR_ENABLE_PRIMARY: reg_rdata <= en1_q;
                `ADDR_ENABLE_SECONDARY: reg_rdata <= {en2_q, 7'h00};
                `ADDR_PROX_THRESH: reg_rdata <= thresh_q;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    assign irq_n = !(|(flags1_q & en1_q) || (flag2_q && en2_q));
endmodule // afe_irq_flags

// [inc/afe_irq_map.vh]
`ifndef AFE_IRQ_MAP_VH
`define AFE_IRQ_MAP_VH
`define ADDR_FLAGS_PRIMARY 8'h00
`define ADDR_FLAGS_SECONDARY 8'h01
`define ADDR_ENABLE_PRIMARY 8'h02
`define ADDR_ENABLE_SECONDARY 8'h03
`define ADDR_FIFO_DATA 8'h07
`define ADDR_PROX_THRESH 8'h10
`define BIT_ALMOST_FULL 7
`define BIT_SAMPLE_READY 6
`define BIT_AMBIENT_OVF 5
`define BIT_PROXIMITY 4
`define BIT_HEADROOM 3
`define BIT_POWER_UP 0
`define BIT_SUPPLY_RANGE 7
`define FLAGS_RESET 8'h00
`define ENABLE_RESET 8'h00
`define PROX_SCALE_SHIFT 11
`define SUPPLY_QUAL_MS 10
`define CLK_MHZ 250
`define SUPPLY_QUAL_CYCLES (`SUPPLY_QUAL_MS * 1000 * `CLK_MHZ)
`endif

// [sim/afe_irq_flags_checker.sv]
`timescale 1ns/100ps
module afe_irq_flags_checker #(parameter QUAL_CYCLES = 20) (
    input wire mclk, rst, reg_rd, almost_full_next, sample_written, ambient_cancel_sat,
    input wire sample_end, prox_sample_valid, digital_supply_low, soft_reset, proximity_mode,
    input wire analog_supply_oor, irq_n,
    input wire [7:0] reg_addr, reg_rdata
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire rd0 = reg_rd && reg_addr == 8'h00;
    wire quiet = !(almost_full_next | sample_written | ambient_cancel_sat | sample_end
        | prox_sample_valid | digital_supply_low | soft_reset);
    property p_rst; disable iff (1'b0) rst |=> reg_rdata == 8'h00 && irq_n; endproperty
    property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    property p_unmap; reg_rd && reg_addr == 8'h05 |=> reg_rdata == 8'h00; endproperty
    property p_pwr; soft_reset ##1 (!reg_rd)[*4] ##1 rd0 |=> reg_rdata[0]; endproperty
    property p_win; soft_reset && rd0 ##1 rd0 |=> reg_rdata[0]; endproperty
    property p_clr; rd0 && quiet ##1 rd0 && quiet |=> reg_rdata == 8'h00; endproperty
    property p_irq; rd0 && quiet ##1 reg_rd && reg_addr == 8'h01 && !analog_supply_oor
        |=> irq_n; endproperty
    property p_prox; $rose(proximity_mode) |-> $past(prox_sample_valid); endproperty
    a_rst: assert property (p_rst) else $error("reset");
    a_hold: assert property (p_hold) else $error("hold");
    a_unmap: assert property (p_unmap) else $error("unmapped");
    a_pwr: assert property (p_pwr) else $error("power");
    a_win: assert property (p_win) else $error("set lost");
    a_clr: assert property (p_clr) else $error("clear");
    a_irq: assert property (p_irq) else $error("irq");
    a_prox: assert property (p_prox) else $error("prox");
    c_win: cover property (soft_reset && rd0);
    c_prox: cover property ($rose(proximity_mode));
    c_irq: cover property ($fell(irq_n));
endmodule // afe_irq_flags_checker
bind afe_irq_flags afe_irq_flags_checker #(.QUAL_CYCLES(QUAL_CYCLES)) u_chk (.*);

// [sim/afe_host.sv]
`timescale 1ns/100ps
module afe_host (
    input wire mclk,
    output logic reg_rd, reg_wr,
    output logic [7:0] reg_addr, reg_wdata,
    input wire [7:0] reg_rdata
);
    initial {reg_rd, reg_wr, reg_addr, reg_wdata} = 18'h0;
    // one access per two cycles, held strobe allows back to back
    task xfer(input w, input [7:0] a, v, output [7:0] q, input k);
        {reg_rd, reg_wr, reg_addr, reg_wdata} = {!w, w, a, v};
        @(negedge mclk);
        q = reg_rdata;
        if (!k) begin
            {reg_rd, reg_wr, reg_addr, reg_wdata} = {2'h0, ~a, ~v};
            @(negedge mclk);
        end
    endtask
endmodule // afe_host

// [sim/test_optical_afe_interrupt_flags.sv]
`timescale 1ns/100ps
module test_optical_afe_interrupt_flags;
    logic mclk = 0, rst = 1, cod = 0, opt = 0, sv = 0, oor = 0, hr = 0;
    logic [5:0] ev = 6'h00;
    logic [18:0] cnt = 19'h00000;
    logic [7:0] d;
    logic [31:0] r;
    wire rs, ws, pm, irq_n;
    wire [7:0] a, wd, q;
    int mismatches = 0, num_checks = 0;
    logic [31:0] rows [8] = '{32'hF8010080, 32'hF8020140, 32'hF80A0000, 32'hF8040020,
        32'hF8080008, 32'h000E0100, 32'h00100001, 32'h00200001};
    always #2 mclk = ~mclk;
    afe_irq_flags #(.QUAL_CYCLES(20)) DUT (.mclk, .rst, .reg_rd(rs), .reg_wr(ws),
        .reg_addr(a), .reg_wdata(wd), .reg_rdata(q), .clear_on_data_read(cod),
        .optical_mode(opt), .almost_full_next(ev[0]), .sample_written(ev[1]),
        .ambient_cancel_sat(ev[2]), .sample_end(ev[3]), .first_emitter_low_headroom(hr),
        .first_emitter_count(cnt), .prox_sample_valid(sv), .digital_supply_low(ev[5]),
        .soft_reset(ev[4]), .analog_supply_oor(oor), .proximity_mode(pm), .irq_n);
    afe_host h (.mclk, .reg_rd(rs), .reg_wr(ws), .reg_addr(a), .reg_wdata(wd), .reg_rdata(q));
    task chk(input [7:0] g, e);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task rd(input [7:0] x, input k); h.xfer(1'b0, x, 8'h00, d, k); endtask
    task wr(input [7:0] x, v); h.xfer(1'b1, x, v, d, 1'b0); endtask
    task tick(input int n); repeat (n) @(negedge mclk); endtask
    task prox(input [18:0] c, input [7:0] e);
        cnt = c;
        sv = 1;
        tick(1);
        sv = 0;
        tick(1);
        chk({7'h00, pm}, e);
    endtask
    task conclude;
        if (mismatches == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        tick(12);
        rst = 0;
        wr(8'h00, 8'hFF);
        rd(8'h00, 1);
        chk(d, 8'h00);
        rd(8'h05, 0);
        chk(d, 8'h00);
        foreach (rows[i]) begin
            r = rows[i];
            wr(8'h02, r[31:24]);
            opt = r[8];
            hr = r[3];
            ev = r[21:16];
            tick(1);
            ev = r[21:16] & 6'h20;
            if (ev[5]) tick(2);
            ev = 6'h00;
            tick(4);
            if (r[7:3] != 0) chk({7'h00, irq_n}, 8'h00);
            rd(8'h00, 1);
            chk(d, r[7:0]);
            rd(8'h00, 1);
            chk(d, 8'h00);
            rd(8'h01, 0);
            chk({7'h00, irq_n}, 8'h01);
        end
        wr(8'h02, 8'hC0);
        opt = 1;
        for (int c = 1; c >= 0; c--) begin
            cod = c[0];
            ev = 6'h03;
            tick(1);
            ev = 6'h00;
            rd(8'h07, 1);
            rd(8'h00, 0);
            chk(d, c ? 8'h00 : 8'hC0);
        end
        ev = 6'h10;
        rd(8'h00, 1);
        ev = 6'h00;
        rd(8'h00, 0);
        chk(d, 8'h01);
        wr(8'h10, 8'h02);
        wr(8'h02, 8'h10);
        prox(19'h01000, 8'h01);
        prox(19'h01001, 8'h00);
        rd(8'h00, 0);
        chk(d, 8'h10);
        wr(8'h02, 8'h00);
        prox(19'h00000, 8'h00);
        wr(8'h03, 8'h80);
        oor = 1;
        tick(12);
        rd(8'h01, 0);
        chk(d, 8'h00);
        tick(30);
        rd(8'h01, 0);
        chk(d, 8'h80);
        rst = 1;
        tick(2);
        rst = 0;
        rd(8'h01, 0);
        chk(d, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        conclude;
    end
endmodule // test_optical_afe_interrupt_flags
